/* src/ema_ext_alu.v */
// extended data-memory alu: accumulator, flags and data memory
// assumes: apb master on pclk; one command executes per cmd write
`timescale 1ns/1ps
`include "ema_defs.vh"

// Behaviour
// RULE1 - full flat address, no bank selection used
// RULE2 - add with carry, all five flags updated
// RULE3 - plain add, no carry in, flags updated
// RULE4 - and of acc and byte, zero flag only
// RULE5 - or of acc and byte, zero flag only
// RULE6 - clear byte or one bit, no flags
// RULE7 - invert byte to mem or acc, zero only
// RULE8 - bcd adjust adds 00, 06, 60 or 66
// RULE9 - bcd result to memory, only carry changes
// RULE10 - decrement byte to mem or acc, zero only
// RULE11 - increment byte to mem or acc, zero only
// RULE12 - move byte to acc or back, no flags
// RULE13 - rotate left, bit 7 wraps to bit 0
// RULE14 - rotate left through carry
// RULE15 - rotate right, bit 0 wraps to bit 7
// RULE16 - rotate right through carry
// RULE17 - subtract byte and inverted carry, six flags
// RULE18 - carry is inverted borrow on subtract
// RULE19 - acc-destination variants leave memory untouched
// RULE20 - ov, sc, cz follow core arithmetic conventions
module ema_ext_alu #(
    parameter MEM_DEPTH = 384,
    parameter ADDR_W = 9
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output wire [31:0] prdata
);

reg [7:0] accumulator_ff;
reg [7:0] nxt_accumulator;
reg carry_ff;
reg aux_carry_flag_ff;
reg zero_ff;
reg overflow_flag_ff;
reg secondary_sign_flag_ff;
reg chained_zero_flag_ff;
reg nxt_carry;
reg nxt_aux_carry;
reg nxt_zero;
reg nxt_overflow;
reg nxt_sign;
reg nxt_chained_zero;
reg bad_op_ff;
reg [ADDR_W-1:0] mem_addr_ff;
reg [31:0] prdata_ff;
reg [31:0] nxt_prdata;
reg [7:0] mem [0:MEM_DEPTH-1];

reg [7:0] alu_res;
reg mem_we;
reg acc_we;
reg op_bad;
reg [7:0] bcd_add;
reg [8:0] sum9;
reg [4:0] sum5;
reg [7:0] add_b;
reg add_cin;
reg is_sub;

wire setup = psel & ~penable;
wire wr_acc = psel & penable & pwrite;
wire hit_cmd = (paddr == `EMA_OFS_CMD);
wire hit_acc = (paddr == `EMA_OFS_ACC);
wire hit_flags = (paddr == `EMA_OFS_FLAGS);
wire hit_stat = (paddr == `EMA_OFS_STAT);
wire hit_maddr = (paddr == `EMA_OFS_MADDR);
wire hit_mdata = (paddr == `EMA_OFS_MDATA);
wire hit_any = hit_cmd | hit_acc | hit_flags | hit_stat | hit_maddr
    | hit_mdata;

// command fields come straight off the write data, so the op runs
// on the same edge that completes the cmd write
wire go = wr_acc & hit_cmd;
wire [4:0] op = pwdata[`EMA_CMD_OP_HI:`EMA_CMD_OP_LO];
wire [2:0] bit_sel = pwdata[`EMA_CMD_BIT_HI:`EMA_CMD_BIT_LO];
wire [ADDR_W-1:0] op_addr =
    pwdata[`EMA_CMD_ADR_LO+ADDR_W-1:`EMA_CMD_ADR_LO]; // [RULE1]
wire addr_ok = (op_addr < MEM_DEPTH);
wire [7:0] m = addr_ok ? mem[op_addr] : 8'h00;
wire [7:0] a = accumulator_ff;
wire maddr_ok = (mem_addr_ff < MEM_DEPTH);

// zero-wait slave; only unmapped addresses answer with an error
assign pready = 1'b1;
assign pslverr = psel & penable & ~hit_any;
assign prdata = prdata_ff;

// shared adder for add, add with carry and subtract with borrow
always @*
begin
    is_sub = (op == `EMA_OP_SBC_ACC) || (op == `EMA_OP_SBC_MEM);
    add_b = is_sub ? ~m : m; // [RULE17]
    case (op)
        `EMA_OP_ADC_ACC, `EMA_OP_ADC_MEM:
            add_cin = carry_ff; // [RULE2]
        `EMA_OP_SBC_ACC, `EMA_OP_SBC_MEM:
            add_cin = carry_ff; // [RULE17]
        default:
            add_cin = 1'b0; // [RULE3]
    endcase
    sum9 = {1'b0, a} + {1'b0, add_b} + {8'h00, add_cin};
    sum5 = {1'b0, a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
end

// bcd correction term from the nibbles and current carries
always @*
begin
    bcd_add = 8'h00;
    if ((a[3:0] > `EMA_BCD_NINE) || aux_carry_flag_ff)
    begin
        bcd_add = bcd_add | `EMA_BCD_LO_ADD; // [RULE8]
    end
    if ((a[7:4] > `EMA_BCD_NINE) || carry_ff)
    begin
        bcd_add = bcd_add | `EMA_BCD_HI_ADD; // [RULE8]
    end
end

// result, destination and flag update per operation
always @*
begin
    alu_res = m;
    mem_we = 1'b0;
    acc_we = 1'b0;
    op_bad = 1'b0;
    nxt_carry = carry_ff;
    nxt_aux_carry = aux_carry_flag_ff;
    nxt_zero = zero_ff;
    nxt_overflow = overflow_flag_ff;
    nxt_sign = secondary_sign_flag_ff;
    nxt_chained_zero = chained_zero_flag_ff;
    case (op)
        `EMA_OP_ADC_ACC, `EMA_OP_ADD_ACC, `EMA_OP_SBC_ACC,
        `EMA_OP_ADC_MEM, `EMA_OP_ADD_MEM, `EMA_OP_SBC_MEM:
        begin
            alu_res = sum9[7:0]; // [RULE2] [RULE3]
            // on subtract the adder carry is already not-borrow
            nxt_carry = sum9[8]; // [RULE18]
            nxt_aux_carry = sum5[4];
            nxt_zero = (sum9[7:0] == 8'h00);
            nxt_overflow = (a[7] == add_b[7]) && (sum9[7] != a[7]);
            nxt_sign = nxt_overflow ^ sum9[7]; // [RULE20]
            if (is_sub)
            begin
                // chained zero keeps earlier bytes' zero state [RULE20]
                nxt_chained_zero = nxt_zero & chained_zero_flag_ff;
            end
            acc_we = (op == `EMA_OP_ADC_ACC) || (op == `EMA_OP_ADD_ACC)
                || (op == `EMA_OP_SBC_ACC);
            mem_we = ~acc_we;
        end
        `EMA_OP_AND_ACC, `EMA_OP_AND_MEM:
        begin
            alu_res = a & m; // [RULE4]
            nxt_zero = ((a & m) == 8'h00);
            acc_we = (op == `EMA_OP_AND_ACC);
            mem_we = ~acc_we;
        end
        `EMA_OP_OR_ACC, `EMA_OP_OR_MEM:
        begin
            alu_res = a | m; // [RULE5]
            nxt_zero = ((a | m) == 8'h00);
            acc_we = (op == `EMA_OP_OR_ACC);
            mem_we = ~acc_we;
        end
        `EMA_OP_CLR_MEM:
        begin
            alu_res = 8'h00; // [RULE6]
            mem_we = 1'b1;
        end
        `EMA_OP_CLR_BIT:
        begin
            alu_res = m & ~(8'h01 << bit_sel); // [RULE6]
            mem_we = 1'b1;
        end
        `EMA_OP_INV_MEM, `EMA_OP_INV_ACC:
        begin
            alu_res = ~m; // [RULE7]
            nxt_zero = (m == 8'hff);
            acc_we = (op == `EMA_OP_INV_ACC);
            mem_we = ~acc_we;
        end
        `EMA_OP_BCD_MEM:
        begin
            alu_res = a + bcd_add; // [RULE9]
            // carry only set here, never cleared: a hundred or more
            nxt_carry = carry_ff
                | ((({1'b0, a} + {1'b0, bcd_add}) >> 8) != 9'h000);
            mem_we = 1'b1;
        end
        `EMA_OP_DEC_MEM, `EMA_OP_DEC_ACC:
        begin
            alu_res = m - 8'h01; // [RULE10]
            nxt_zero = (m == 8'h01);
            acc_we = (op == `EMA_OP_DEC_ACC);
            mem_we = ~acc_we;
        end
        `EMA_OP_INC_MEM, `EMA_OP_INC_ACC:
        begin
            alu_res = m + 8'h01; // [RULE11]
            nxt_zero = (m == 8'hff);
            acc_we = (op == `EMA_OP_INC_ACC);
            mem_we = ~acc_we;
        end
        `EMA_OP_MOV_ACC:
        begin
            alu_res = m; // [RULE12]
            acc_we = 1'b1;
        end
        `EMA_OP_MOV_MEM:
        begin
            alu_res = a; // [RULE12]
            mem_we = 1'b1;
        end
        `EMA_OP_RL_MEM, `EMA_OP_RL_ACC:
        begin
            alu_res = {m[6:0], m[7]}; // [RULE13]
            acc_we = (op == `EMA_OP_RL_ACC);
            mem_we = ~acc_we;
        end
        `EMA_OP_RLC_MEM, `EMA_OP_RLC_ACC:
        begin
            alu_res = {m[6:0], carry_ff}; // [RULE14]
            nxt_carry = m[7];
            acc_we = (op == `EMA_OP_RLC_ACC);
            mem_we = ~acc_we;
        end
        `EMA_OP_RR_MEM, `EMA_OP_RR_ACC:
        begin
            alu_res = {m[0], m[7:1]}; // [RULE15]
            acc_we = (op == `EMA_OP_RR_ACC);
            mem_we = ~acc_we;
        end
        `EMA_OP_RRC_MEM, `EMA_OP_RRC_ACC:
        begin
            alu_res = {carry_ff, m[7:1]}; // [RULE16]
            nxt_carry = m[0];
            acc_we = (op == `EMA_OP_RRC_ACC);
            mem_we = ~acc_we;
        end
        default:
        begin
            op_bad = 1'b1;
        end
    endcase
    // out-of-range byte: memory is not written, acc and flags still follow
    mem_we = mem_we & addr_ok; // [RULE19]
end

// accumulator source: command result wins over a plain write
always @*
begin
    nxt_accumulator = accumulator_ff;
    if (go && acc_we)
    begin
        nxt_accumulator = alu_res; // [RULE19]
    end
    else if (wr_acc && hit_acc)
    begin
        nxt_accumulator = pwdata[7:0];
    end
end

// read data is captured in the setup phase and held for access
always @*
begin
    nxt_prdata = prdata_ff;
    if (setup)
    begin
        nxt_prdata = `EMA_RST_DATA;
        if (hit_acc)
        begin
            nxt_prdata[7:0] = accumulator_ff;
        end
        else if (hit_flags)
        begin
            nxt_prdata[`EMA_FLG_W-1:0] = {chained_zero_flag_ff,
                secondary_sign_flag_ff, overflow_flag_ff, zero_ff,
                aux_carry_flag_ff, carry_ff};
        end
        else if (hit_stat)
        begin
            nxt_prdata[`EMA_STAT_BADOP] = bad_op_ff;
        end
        else if (hit_maddr)
        begin
            nxt_prdata[ADDR_W-1:0] = mem_addr_ff;
        end
        else if (hit_mdata && maddr_ok)
        begin
            nxt_prdata[7:0] = mem[mem_addr_ff];
        end
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        accumulator_ff <= `EMA_RST_ACC;
        {chained_zero_flag_ff, secondary_sign_flag_ff, overflow_flag_ff,
            zero_ff, aux_carry_flag_ff, carry_ff} <= `EMA_RST_FLAGS;
        bad_op_ff <= 1'b0;
        mem_addr_ff <= {ADDR_W{1'b0}};
        prdata_ff <= `EMA_RST_DATA;
    end
    else
    begin
        accumulator_ff <= nxt_accumulator;
        prdata_ff <= nxt_prdata;
        if (go)
        begin
            carry_ff <= nxt_carry;
            aux_carry_flag_ff <= nxt_aux_carry;
            zero_ff <= nxt_zero;
            overflow_flag_ff <= nxt_overflow;
            secondary_sign_flag_ff <= nxt_sign;
            chained_zero_flag_ff <= nxt_chained_zero;
        end
        else if (wr_acc && hit_flags)
        begin
            carry_ff <= pwdata[`EMA_FLG_C];
            aux_carry_flag_ff <= pwdata[`EMA_FLG_AC];
            zero_ff <= pwdata[`EMA_FLG_Z];
            overflow_flag_ff <= pwdata[`EMA_FLG_OV];
            secondary_sign_flag_ff <= pwdata[`EMA_FLG_SC];
            chained_zero_flag_ff <= pwdata[`EMA_FLG_CZ];
        end
        // sticky bad-op flag, write one to clear; a new set wins
        if (go && op_bad)
        begin
            bad_op_ff <= 1'b1;
        end
        else if (wr_acc && hit_stat && pwdata[`EMA_STAT_BADOP])
        begin
            bad_op_ff <= 1'b0;
        end
        if (wr_acc && hit_maddr)
        begin
            mem_addr_ff <= pwdata[ADDR_W-1:0];
        end
    end
end

// data memory has no reset: contents are undefined until written
always @(posedge pclk)
begin
    if (go && mem_we)
    begin
        mem[op_addr] <= alu_res; // [RULE19]
    end
    else if (wr_acc && hit_mdata && maddr_ok)
    begin
        mem[mem_addr_ff] <= pwdata[7:0];
    end
end

endmodule

/* src/ema_defs.vh */
// constants for the extended data-memory alu block
// assumes: included by ema_ext_alu.v, byte addresses on a 32-bit apb
`ifndef EMA_DEFS_VH
`define EMA_DEFS_VH

// apb register byte offsets
`define EMA_OFS_CMD 12'h000
`define EMA_OFS_ACC 12'h004
`define EMA_OFS_FLAGS 12'h008
`define EMA_OFS_STAT 12'h00c
`define EMA_OFS_MADDR 12'h010
`define EMA_OFS_MDATA 12'h014

// command word fields
`define EMA_CMD_OP_HI 4
`define EMA_CMD_OP_LO 0
`define EMA_CMD_BIT_HI 10
`define EMA_CMD_BIT_LO 8
`define EMA_CMD_ADR_LO 16

// flag register bit positions
`define EMA_FLG_C 0
`define EMA_FLG_AC 1
`define EMA_FLG_Z 2
`define EMA_FLG_OV 3
`define EMA_FLG_SC 4
`define EMA_FLG_CZ 5
`define EMA_FLG_W 6

// status register bit positions
`define EMA_STAT_BADOP 0

// reset values
`define EMA_RST_ACC 8'h00
`define EMA_RST_FLAGS 6'h00
`define EMA_RST_DATA 32'h0000_0000

// bcd adjust addends and limits
`define EMA_BCD_NINE 4'h9
`define EMA_BCD_LO_ADD 8'h06
`define EMA_BCD_HI_ADD 8'h60

// operation codes
`define EMA_OP_ADC_ACC 5'h00
`define EMA_OP_ADC_MEM 5'h01
`define EMA_OP_ADD_ACC 5'h02
`define EMA_OP_ADD_MEM 5'h03
`define EMA_OP_AND_ACC 5'h04
`define EMA_OP_AND_MEM 5'h05
`define EMA_OP_CLR_MEM 5'h06
`define EMA_OP_CLR_BIT 5'h07
`define EMA_OP_INV_MEM 5'h08
`define EMA_OP_INV_ACC 5'h09
`define EMA_OP_BCD_MEM 5'h0a
`define EMA_OP_DEC_MEM 5'h0b
`define EMA_OP_DEC_ACC 5'h0c
`define EMA_OP_INC_MEM 5'h0d
`define EMA_OP_INC_ACC 5'h0e
`define EMA_OP_MOV_ACC 5'h0f
`define EMA_OP_MOV_MEM 5'h10
`define EMA_OP_OR_ACC 5'h11
`define EMA_OP_OR_MEM 5'h12
`define EMA_OP_RL_MEM 5'h13
`define EMA_OP_RL_ACC 5'h14
`define EMA_OP_RLC_MEM 5'h15
`define EMA_OP_RLC_ACC 5'h16
`define EMA_OP_RR_MEM 5'h17
`define EMA_OP_RR_ACC 5'h18
`define EMA_OP_RRC_MEM 5'h19
`define EMA_OP_RRC_ACC 5'h1a
`define EMA_OP_SBC_ACC 5'h1b
`define EMA_OP_SBC_MEM 5'h1c

`endif

/* bench/ema_ext_alu_sva.sv */
// apb port checker for the extended memory alu
// assumes: bound to ema_ext_alu, zero wait states
`timescale 1ns/1ps
module ema_ext_alu_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire acc_ph = psel && penable;
    wire rd_ph = acc_ph && !pwrite;
    AST_READY:
        assert property (pready) else $error("pready low");
    AST_ERR_MAP:
        assert property (acc_ph && paddr > 12'h014 |-> pslverr)
        else $error("unmapped access not refused");
    AST_ERR_IDLE:
        assert property (!acc_ph |-> !pslverr) else $error("stray error");
    AST_ERR_OK:
        assert property (acc_ph && paddr <= 12'h014 && paddr[1:0] == 2'b00
            |-> !pslverr) else $error("mapped access refused");
    AST_HOLD:
        assert property (acc_ph |=> $stable(prdata))
        else $error("read data moved after access");
    AST_ERR_RD0:
        assert property (rd_ph && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read not zero");
    AST_MEM_BYTE:
        assert property (rd_ph && paddr == 12'h014 |-> prdata[31:8] == 0)
        else $error("memory byte wider than eight bits");
    AST_FLAG_BITS:
        assert property (rd_ph && paddr == 12'h008 |-> prdata[31:6] == 0)
        else $error("flag register upper bits set");
    cover property (acc_ph && pwrite && paddr == 12'h000);
    cover property (rd_ph && paddr == 12'h004);
    cover property (acc_ph && pslverr);
endmodule

bind ema_ext_alu ema_ext_alu_chk i_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata)
);

/* bench/ema_apb_mst.sv */
// apb master standing in for the core side of the block
// assumes: one transfer at a time, waits on pready
`timescale 1ns/1ps
module ema_apb_mst (
    input wire pclk,
    input wire pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // idle cycle between transfers keeps prdata quiet for the monitor
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule

/* bench/tb.sv */
// self-checking bench for the extended memory alu
// assumes: apb master model drives, monitor checks reads
`timescale 1ns/1ps
`include "ema_defs.vh"
module tb;
    logic pclk;
    logic presetn;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [32:0] q[$];
    logic [7:0] a, m, ea, em, r, b, ad;
    logic [5:0] f, ef;
    logic [8:0] s, adr;
    logic [2:0] bi;
    logic eb, ci;
    int err_count, comparisons;
    ema_ext_alu i_ema_ext_alu (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata));
    ema_apb_mst i_ema_apb_mst (.pclk(pclk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task finish_test;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task cmp(input logic [32:0] x, input logic [32:0] g);
        begin
            comparisons++;
            if (g !== x)
            begin
                err_count++;
                $display("ERROR %0t exp %h got %h", $time, x, g);
            end
        end
    endtask
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && q.size() > 0)
            cmp(q.pop_front(), {pslverr, prdata});
    task wr(input logic [11:0] ad_, input logic [31:0] d);
        i_ema_apb_mst.xfer(1'b1, ad_, d);
    endtask
    task rd(input logic [11:0] ad_, input logic [32:0] x);
        begin
            q.push_back(x);
            i_ema_apb_mst.xfer(1'b0, ad_, 32'h0000_0000);
        end
    endtask
    // reference model of one command; acc-destination and zero-only masks
    task calc(input logic [4:0] op);
        begin
            b = m;
            ci = 1'b0;
            r = m;
            ea = a;
            em = m;
            ef = f;
            eb = 1'b0;
            case (op)
                5'h00, 5'h01, 5'h02, 5'h03, 5'h1b, 5'h1c:
                begin
                    if (op > 5'h1a)
                        b = ~m;
                    ci = (op == 5'h02 || op == 5'h03) ? 1'b0 : f[0];
                    s = a + b + ci;
                    r = s[7:0];
                    ef[0] = s[8];
                    ef[1] = (a[3:0] + b[3:0] + ci) > 15;
                    ef[2] = r == 0;
                    ef[3] = (a[7] == b[7]) && (r[7] != a[7]);
                    ef[4] = ef[3] ^ r[7];
                    if (op > 5'h1a)
                        ef[5] = ef[2] & f[5];
                end
                5'h04, 5'h05: r = a & m;
                5'h11, 5'h12: r = a | m;
                5'h06: r = 8'h00;
                5'h07: r = m & ~(8'h01 << bi);
                5'h08, 5'h09: r = ~m;
                5'h0b, 5'h0c: r = m - 8'h01;
                5'h0d, 5'h0e: r = m + 8'h01;
                5'h10: r = a;
                5'h13, 5'h14: r = {m[6:0], m[7]};
                5'h15, 5'h16: {ef[0], r} = {m, f[0]};
                5'h17, 5'h18: r = {m[0], m[7:1]};
                5'h19, 5'h1a: {r, ef[0]} = {f[0], m};
                5'h0a:
                begin
                    ad = ((a[3:0] > 9 || f[1]) ? 8'h06 : 8'h00)
                        | ((a[7:4] > 9 || f[0]) ? 8'h60 : 8'h00);
                    s = a + ad;
                    r = s[7:0];
                    ef[0] = f[0] | s[8];
                end
                5'h0f: r = m;
                default: eb = 1'b1;
            endcase
            if (32'h0006_7b30 >> op & 1)
                ef[2] = r == 0;
            if (32'h0d52_d215 >> op & 1)
                ea = r;
            else if (!eb)
                em = r;
        end
    endtask
    initial
    begin
        err_count = 0;
        comparisons = 0;
        #300000;
        err_count++;
        finish_test;
    end
    // seed here: each process has its own generator
    initial
    begin
        presetn = 1'b0;
        void'($urandom(73148));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`EMA_OFS_ACC, 33'h0);
        rd(`EMA_OFS_FLAGS, 33'h0);
        rd(`EMA_OFS_STAT, 33'h0);
        $display("reset test done");
        for (int i = 0; i < 64; i++)
        begin
            adr = 9'($urandom_range(383));
            m = 8'($urandom);
            a = 8'($urandom);
            f = 6'($urandom);
            bi = 3'($urandom);
            calc(5'(i));
            wr(`EMA_OFS_MADDR, {23'h0, adr});
            wr(`EMA_OFS_MDATA, {24'h0, m});
            wr(`EMA_OFS_ACC, {24'h0, a});
            wr(`EMA_OFS_FLAGS, {26'h0, f});
            wr(`EMA_OFS_CMD, {7'h0, adr, 5'h0, bi, 3'h0, 5'(i)});
            rd(`EMA_OFS_ACC, {25'h0, ea});
            rd(`EMA_OFS_FLAGS, {27'h0, ef});
            rd(`EMA_OFS_MDATA, {25'h0, em});
            rd(`EMA_OFS_STAT, {32'h0, eb});
            wr(`EMA_OFS_STAT, 32'h0000_0001);
        end
        $display("op sweep done");
        wr(`EMA_OFS_MADDR, 32'h0000_01ff);
        rd(`EMA_OFS_MADDR, {24'h0, 9'h1ff});
        rd(`EMA_OFS_MDATA, 33'h0);
        // out-of-range command byte reads as zero
        wr(`EMA_OFS_CMD, {7'h0, 9'h1ff, 11'h0, 5'h0e});
        rd(`EMA_OFS_ACC, {25'h0, 8'h01});
        $display("range test done");
        rd(12'h018, {1'b1, 32'h0});
        rd(`EMA_OFS_CMD, 33'h0);
        $display("unmapped test done");
        repeat (2) @(posedge pclk);
        finish_test;
    end
endmodule
